// *** hw/command_parser.sv ***
// Serial command parser with settings registers and Avalon-MM slave
`timescale 1ns/10ps
`include "parser_defs.svh"
module command_parser
  import parser_pkg::*;
#(
  parameter int BIT_CYCLES = `CLK_HZ / `BAUD_RATE,
  parameter int BUF_DEPTH  = `BUF_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        rx_pin,
  output logic             tx_pin,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        op_done,
  output logic             op_start,
  output settings_t        op_params
);

  localparam int CNT_W = $clog2(BIT_CYCLES) + 1;
  localparam int IDX_W = $clog2(BUF_DEPTH + 1);

  if (BIT_CYCLES < 16 || BUF_DEPTH < 2) begin : g_bad_params
    $error("command_parser: BIT_CYCLES or BUF_DEPTH too small");
  end

  // Receiver
  logic             rx_meta_reg;
  logic             rx_sync_reg;
  logic             rx_busy_reg;
  logic [CNT_W-1:0] rx_cnt_reg;
  logic [3:0]       rx_bit_reg;
  logic [7:0]       rx_sh_reg;
  logic             rx_valid_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rx_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Start found mid-bit, samples at bit centres
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_busy_reg  <= 1'b0;
      rx_cnt_reg   <= '0;
      rx_bit_reg   <= 4'h0;
      rx_sh_reg    <= 8'h00;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (!rx_sync_reg) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg  <= CNT_W'(BIT_CYCLES / 2);
          rx_bit_reg  <= 4'h0;
        end
      end else if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - 1'b1;
      end else begin
        rx_cnt_reg <= CNT_W'(BIT_CYCLES - 1);
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0) begin
          rx_busy_reg <= !rx_sync_reg;
        end else if (rx_bit_reg < 4'h9) begin
          rx_sh_reg <= {rx_sync_reg, rx_sh_reg[7:1]};
        end else begin
          rx_busy_reg  <= 1'b0;
          rx_valid_reg <= rx_sync_reg;
        end
      end
    end
  end

  // Transmitter
  logic             tx_busy_reg;
  logic [CNT_W-1:0] tx_cnt_reg;
  logic [3:0]       tx_bit_reg;
  logic [9:0]       tx_sh_reg;
  logic             tx_go_reg;
  logic [7:0]       tx_char_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_busy_reg <= 1'b0;
      tx_cnt_reg  <= '0;
      tx_bit_reg  <= 4'h0;
      tx_sh_reg   <= 10'h3FF;
    end else if (tx_go_reg) begin
      tx_busy_reg <= 1'b1;
      tx_cnt_reg  <= CNT_W'(BIT_CYCLES - 1);
      tx_bit_reg  <= 4'h0;
      tx_sh_reg   <= {1'b1, tx_char_reg, 1'b0};
    end else if (tx_busy_reg) begin
      if (tx_cnt_reg != '0) begin
        tx_cnt_reg <= tx_cnt_reg - 1'b1;
      end else begin
        tx_cnt_reg  <= CNT_W'(BIT_CYCLES - 1);
        tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
        tx_bit_reg  <= tx_bit_reg + 4'h1;
        tx_busy_reg <= tx_bit_reg != 4'h9;
      end
    end
  end

  assign tx_pin = tx_sh_reg[0];

  // Command line and parse state
  logic [7:0]       buf_mem [BUF_DEPTH];
  logic [IDX_W-1:0] len_reg;
  logic [IDX_W-1:0] idx_reg;
  logic             ovf_reg;
  parse_state_t     st_reg;
  parse_phase_t     phase_reg;
  logic [7:0]       cmd_reg;
  logic [15:0]      v1_reg;
  logic [15:0]      v2_reg;
  logic             v2_has_reg;
  logic [7:0]       code_reg;
  logic [15:0]      resp_v2_reg;
  logic [2:0]       field_reg;
  logic [15:0]      conv_reg;
  logic [3:0]       stk_reg [5];
  logic [2:0]       sp_reg;
  settings_t        set_reg;
  logic             op_active_reg;
  logic             ack_reg;

  logic [7:0]  cur_char;
  logic        is_digit;
  logic        is_alpha;
  logic [19:0] acc;
  logic [15:0] acc_sat;

  always_comb begin
    cur_char = buf_mem[idx_reg[$clog2(BUF_DEPTH)-1:0]];
    is_digit = cur_char >= `CHR_ZERO && cur_char <= `CHR_NINE;
    is_alpha = (cur_char >= `CHR_UC_A && cur_char <= `CHR_UC_Z) ||
               (cur_char >= `CHR_LC_A && cur_char <= `CHR_LC_Z);
    acc = ({4'h0, (phase_reg == PH_VAL1) ? v1_reg : v2_reg} * 20'd10)
          + {16'h0000, cur_char[3:0]};
    acc_sat = (acc > 20'h0FFFF) ? 16'hFFFF : acc[15:0];
  end

  // Command decision at the end of the scan
  logic [7:0]  ex_code;
  logic [15:0] ex_v2;
  logic        we_load;
  logic        we_reload;
  logic        we_pdir;
  logic        we_fdir;
  logic        we_mode;
  logic        go_op;
  logic        v2_big;

  always_comb begin
    ex_code   = ovf_reg ? `CODE_OVERFLOW : code_reg;
    ex_v2     = v2_reg;
    we_load   = 1'b0;
    we_reload = 1'b0;
    we_pdir   = 1'b0;
    we_fdir   = 1'b0;
    we_mode   = 1'b0;
    go_op     = 1'b0;
    v2_big    = v2_has_reg && v2_reg > 16'h0001;
    if (st_reg == ST_EXEC && ex_code == `CODE_NONE) begin
      if (phase_reg == PH_CMD) begin
        ex_code = `CODE_UNKNOWN;
      end else begin
        case (cmd_reg)
          `CMD_LOAD: begin
            if (v1_reg == 16'h0000) begin
              ex_code = v2_big ? `CODE_RANGE : `CODE_NONE;
              we_load = v2_has_reg && !v2_big;
              ex_v2 = v2_has_reg ? v2_reg : {15'h0000, set_reg.load_op};
            end else if (v1_reg == 16'h0004) begin
              we_reload = v2_has_reg;
              ex_v2 = v2_has_reg ? v2_reg : set_reg.reload;
            end else begin
              ex_code = `CODE_UNKNOWN;
            end
          end
          `CMD_BEGIN: begin
            ex_v2 = 16'h0000;
            if (v1_reg != 16'h0000) begin
              ex_code = `CODE_UNKNOWN;
            end else if (op_active_reg) begin
              ex_code = `CODE_BUSY;
            end else begin
              go_op = 1'b1;
            end
          end
          `CMD_DIR: begin
            if (v1_reg > 16'h0001) begin
              ex_code = `CODE_UNKNOWN;
            end else begin
              ex_code = v2_big ? `CODE_RANGE : `CODE_NONE;
              we_pdir = v2_has_reg && !v2_big && !v1_reg[0];
              we_fdir = v2_has_reg && !v2_big && v1_reg[0];
              ex_v2 = v2_has_reg ? v2_reg : {15'h0000,
                v1_reg[0] ? set_reg.fluid_dir : set_reg.prod_dir};
            end
          end
          `CMD_MODE: begin
            if (v1_reg != 16'h0000) begin
              ex_code = `CODE_UNKNOWN;
            end else if (v2_has_reg && (v2_reg > 16'h0003 ||
                         v2_reg == 16'h0001)) begin
              ex_code = `CODE_RANGE;
            end else begin
              we_mode = v2_has_reg;
              ex_v2 = v2_has_reg ? v2_reg : {14'h0000, set_reg.mode};
            end
          end
          default: ex_code = `CODE_UNKNOWN;
        endcase
      end
    end
  end

  // Character for the current response position
  logic [7:0] send_char;

  always_comb begin
    case (field_reg)
      3'd0:    send_char = (phase_reg == PH_CMD) ? `CHR_ERR : cmd_reg;
      3'd2,
      3'd4:    send_char = `CHR_COMMA;
      3'd6:    send_char = `CHR_CR;
      default: send_char = `CHR_ZERO + {4'h0, stk_reg[sp_reg - 3'd1]};
    endcase
  end

  // Sequencer: collect, scan, decide, answer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg      <= ST_COLLECT;
      len_reg     <= '0;
      idx_reg     <= '0;
      ovf_reg     <= 1'b0;
      phase_reg   <= PH_CMD;
      cmd_reg     <= 8'h00;
      v1_reg      <= 16'h0000;
      v2_reg      <= 16'h0000;
      v2_has_reg  <= 1'b0;
      code_reg    <= `CODE_NONE;
      resp_v2_reg <= 16'h0000;
      field_reg   <= 3'd0;
      conv_reg    <= 16'h0000;
      sp_reg      <= 3'd0;
      tx_go_reg   <= 1'b0;
      tx_char_reg <= 8'h00;
    end else begin
      tx_go_reg <= 1'b0;
      case (st_reg)
        ST_COLLECT: begin
          // Nothing is echoed; input is only stored
          if (rx_valid_reg) begin
            if (rx_sh_reg == `CHR_CR) begin
              st_reg     <= ST_SCAN;
              idx_reg    <= '0;
              phase_reg  <= PH_CMD;
              cmd_reg    <= 8'h00;
              v1_reg     <= 16'h0000;
              v2_reg     <= 16'h0000;
              v2_has_reg <= 1'b0;
              code_reg   <= `CODE_NONE;
            end else if (len_reg < IDX_W'(BUF_DEPTH)) begin
              len_reg <= len_reg + 1'b1;
            end else begin
              ovf_reg <= 1'b1;
            end
          end
        end
        ST_SCAN: begin
          if (idx_reg == len_reg) begin
            st_reg <= ST_EXEC;
          end else begin
            idx_reg <= idx_reg + 1'b1;
            case (phase_reg)
              PH_CMD: begin
                if (is_alpha) begin
                  cmd_reg   <= cur_char;
                  phase_reg <= PH_VAL1;
                end
              end
              default: begin
                if (is_alpha) begin
                  if (code_reg == `CODE_NONE) begin
                    code_reg <= `CODE_SECOND;
                  end
                end else if (cur_char == `CHR_COMMA) begin
                  if (phase_reg == PH_VAL1) begin
                    phase_reg <= PH_VAL2;
                  end else if (phase_reg == PH_VAL2) begin
                    phase_reg  <= PH_VAL3;
                    v2_has_reg <= 1'b1;
                  end
                end else if (is_digit) begin
                  if (phase_reg == PH_VAL1) begin
                    v1_reg <= acc_sat;
                  end else if (phase_reg == PH_VAL2) begin
                    v2_reg     <= acc_sat;
                    v2_has_reg <= 1'b1;
                  end
                end else if (phase_reg != PH_VAL3 &&
                             code_reg == `CODE_NONE) begin
                  code_reg <= `CODE_SYNTAX;
                end
              end
            endcase
          end
        end
        ST_EXEC: begin
          code_reg    <= ex_code;
          resp_v2_reg <= ex_v2;
          // Lone return is answered by a lone return
          field_reg <= (len_reg == '0 && !ovf_reg) ? 3'd6 : 3'd0;
          st_reg    <= ST_FIELD;
        end
        ST_FIELD: begin
          case (field_reg)
            3'd1: conv_reg <= v1_reg;
            3'd3: conv_reg <= resp_v2_reg;
            default: conv_reg <= {8'h00, code_reg};
          endcase
          sp_reg <= 3'd0;
          st_reg <= field_reg[0] ? ST_CONV : ST_SEND;
        end
        ST_CONV: begin
          stk_reg[sp_reg] <= 4'(conv_reg % 16'd10);
          conv_reg <= conv_reg / 16'd10;
          sp_reg   <= sp_reg + 3'd1;
          if (conv_reg < 16'd10) begin
            st_reg <= ST_SEND;
          end
        end
        ST_SEND: begin
          // Output only ever follows a received return
          if (!tx_busy_reg && !tx_go_reg) begin
            tx_go_reg   <= 1'b1;
            tx_char_reg <= send_char;
            if (field_reg[0] && sp_reg > 3'd1) begin
              sp_reg <= sp_reg - 3'd1;
            end else if (field_reg == 3'd6) begin
              st_reg  <= ST_COLLECT;
              len_reg <= '0;
              ovf_reg <= 1'b0;
            end else begin
              field_reg <= field_reg + 3'd1;
              st_reg    <= ST_FIELD;
            end
          end
        end
        default: st_reg <= ST_COLLECT;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (st_reg == ST_COLLECT && rx_valid_reg && rx_sh_reg != `CHR_CR &&
        len_reg < IDX_W'(BUF_DEPTH)) begin
      buf_mem[len_reg[$clog2(BUF_DEPTH)-1:0]] <= rx_sh_reg;
    end
  end

  // Settings; the serial command wins over a bus write
  logic bus_wr;
  assign bus_wr = avs_write && ack_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      set_reg.load_op   <= `LOAD_RST;
      set_reg.prod_dir  <= `DIR_RST;
      set_reg.fluid_dir <= `DIR_RST;
      set_reg.mode      <= `MODE_RST;
      set_reg.reload    <= `RELOAD_RST;
    end else begin
      if (bus_wr && avs_address == `REG_SETTINGS && avs_byteenable[0]) begin
        set_reg.load_op   <= avs_writedata[0];
        set_reg.prod_dir  <= avs_writedata[1];
        set_reg.fluid_dir <= avs_writedata[2];
        set_reg.mode      <= avs_writedata[5:4];
      end
      if (bus_wr && avs_address == `REG_RELOAD) begin
        if (avs_byteenable[0]) set_reg.reload[7:0]  <= avs_writedata[7:0];
        if (avs_byteenable[1]) set_reg.reload[15:8] <= avs_writedata[15:8];
      end
      if (we_load)   set_reg.load_op   <= v2_reg[0];
      if (we_pdir)   set_reg.prod_dir  <= v2_reg[0];
      if (we_fdir)   set_reg.fluid_dir <= v2_reg[0];
      if (we_mode)   set_reg.mode      <= v2_reg[1:0];
      if (we_reload) set_reg.reload    <= v2_reg;
    end
  end

  // Operation values frozen at begin
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      op_params     <= '0;
      op_start      <= 1'b0;
      op_active_reg <= 1'b0;
    end else begin
      op_start <= go_op;
      if (go_op) begin
        op_params     <= set_reg;
        op_active_reg <= 1'b1;
      end else if (op_done) begin
        op_active_reg <= 1'b0;
      end
    end
  end

  // Avalon-MM slave, one wait state on every access
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
      if (avs_read && !ack_reg) begin
        case (avs_address)
          `REG_SETTINGS: avs_readdata <= {26'h0000000, set_reg.mode, 1'b0,
            set_reg.fluid_dir, set_reg.prod_dir, set_reg.load_op};
          `REG_RELOAD: avs_readdata <= {16'h0000, set_reg.reload};
          `REG_STATUS: avs_readdata <= {8'h00, code_reg, cmd_reg, 6'h00,
            op_active_reg, st_reg != ST_COLLECT};
          `REG_OPERATION: avs_readdata <= {op_params.reload, 10'h000,
            op_params.mode, 1'b0, op_params.fluid_dir,
            op_params.prod_dir, op_params.load_op};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule : command_parser

// *** pkg/parser_defs.svh ***
// Constants of the serial command parser
// Overview of operation
// - Serial framing is 9600 baud, eight data bits, no parity, one stop.
// - Only receive and transmit data lines; no handshake signals at all.
// - Device transmits only in reply to a received command string.
// - Backspace and delete are stored like any other character.
// - Received characters are never echoed; only the response goes out.
// - Commands and responses end with one carriage return, no line feed.
// - Non-letters before the first letter are dropped; that letter is command.
// - A further letter after the command voids it with a warning.
// - Command letters are case sensitive; only lower case is valid.
// - No valid command gives an error; a lone return gives a lone return.
// - First value starts after the letter; non-digit non-comma is an error.
// - A comma directly after the letter means first value zero.
// - Two commas with no digits between give second value zero.
// - Comma then return means no second value was supplied.
// - Third value digits and values the command needs not are ignored.
// - Response echoes letter, two values, then fault code or zero.
// - Begin latches the operation values; later writes affect the next one.
// - Load operation: 0 manual, 1 when empty, 1 after reset.
// - Autoreload count holds up to 65535, readable and writable.
// - Begin with first value zero and no operation active starts production, answers b0,0,0.
// - Both direction settings: 0 reverse, 1 forward, forward after reset.
// - Production mode: 0 disabled, 2 dispense, 3 meter; dispense at reset.
`ifndef PARSER_DEFS_SVH
`define PARSER_DEFS_SVH

`define CLK_HZ        250000000
`define BAUD_RATE     9600
`define BUF_DEPTH     32

`define CHR_CR        8'h0D
`define CHR_COMMA     8'h2C
`define CHR_ZERO      8'h30
`define CHR_NINE      8'h39
`define CHR_ERR       8'h3F
`define CHR_UC_A      8'h41
`define CHR_UC_Z      8'h5A
`define CHR_LC_A      8'h61
`define CHR_LC_Z      8'h7A

`define CMD_LOAD      8'h61
`define CMD_BEGIN     8'h62
`define CMD_DIR       8'h64
`define CMD_MODE      8'h6D

`define CODE_NONE     8'h00
`define CODE_SECOND   8'h01
`define CODE_SYNTAX   8'h02
`define CODE_UNKNOWN  8'h03
`define CODE_RANGE    8'h04
`define CODE_OVERFLOW 8'h05
`define CODE_BUSY     8'h06

`define REG_SETTINGS  4'h0
`define REG_RELOAD    4'h4
`define REG_STATUS    4'h8
`define REG_OPERATION 4'hC

`define MODE_DISABLED 2'h0
`define MODE_DISPENSE 2'h2
`define MODE_METER    2'h3

`define LOAD_RST      1'b1
`define DIR_RST       1'b1
`define MODE_RST      2'h2
`define RELOAD_RST    16'h0000

`endif

// *** pkg/parser_pkg.sv ***
// Types shared by the serial command parser
package parser_pkg;

  typedef struct packed {
    logic [15:0] reload;
    logic [1:0]  mode;
    logic        fluid_dir;
    logic        prod_dir;
    logic        load_op;
  } settings_t;

  typedef enum logic [2:0] {
    ST_COLLECT, ST_SCAN, ST_EXEC, ST_FIELD, ST_CONV, ST_SEND
  } parse_state_t;

  typedef enum logic [1:0] {
    PH_CMD, PH_VAL1, PH_VAL2, PH_VAL3
  } parse_phase_t;

endpackage : parser_pkg

// *** testbench/ascii_serial_command_parser_tb.sv ***
// Self-checking bench for the serial command parser
`timescale 1ns/10ps
module ascii_serial_command_parser_tb
  import parser_pkg::*;
;
  localparam int BIT = 16;
  logic        clock, rstn, rx_pin, tx_pin;
  logic [3:0]  avs_address, avs_byteenable;
  logic        avs_read, avs_write, avs_waitrequest, op_done, op_start;
  logic [31:0] avs_writedata, avs_readdata, rd;
  settings_t   op_params;
  int          errors = 0;
  int          checks_done = 0;
  int          starts = 0;

  command_parser #(.BIT_CYCLES(BIT)) DUT (
    .clock(clock), .rstn(rstn), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .op_done(op_done),
    .op_start(op_start), .op_params(op_params));

  host_terminal #(.BIT_CYCLES(BIT)) host (
    .clock(clock), .to_dev(rx_pin), .from_dev(tx_pin));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) if (op_start === 1'b1) starts <= starts + 1;

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Held until the edge where waitrequest is low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Send, then wait for the reply's return before going on
  task automatic cmd(input string s, input string exp, input bit tail);
    logic [7:0] got[$];
    int         off;
    host.send_str(s);
    do begin
      while (host.rxq.size() == 0) @(posedge clock);
      got.push_back(host.rxq.pop_front());
    end while (got[$] != 8'h0D);
    off = (tail && got.size() > exp.len()) ? got.size() - exp.len() : 0;
    check("reply length", 32'(got.size() - off), 32'(exp.len()));
    for (int i = 0; i < exp.len(); i++) begin
      check("reply char", {24'h0, got[off + i]}, {24'h0, exp[i]});
    end
  endtask : cmd

  initial begin
    repeat (90000) @(posedge clock);
    errors++;
    tally_and_finish();
  end

  initial begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    op_done = 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    check("settings", rd, 32'h27);
    bus(1'b0, 4'h4, 32'h0);
    check("reload", rd, 32'h0);
    repeat (400) @(posedge clock);
    check("silent", host.rxq.size(), 32'h0);
    cmd("\r", "\r", 0);
    cmd("12a0,0\r", "a0,0,0\r", 0);
    bus(1'b0, 4'h0, 32'h0);
    check("load", rd, 32'h26);
    cmd("a0,1\r", "a0,1,0\r", 0);
    cmd("ab\r", ",1\r", 1);
    cmd("A0\r", ",3\r", 1);
    cmd("12\r", ",3\r", 1);
    cmd("a#\r", ",2\r", 1);
    cmd("a0,1\010\r", ",2\r", 1);
    cmd("d,0\r", "d0,0,0\r", 0);
    cmd("a4,65535\r", "a4,65535,0\r", 0);
    bus(1'b0, 4'h4, 32'h0);
    check("reload", rd, 32'hFFFF);
    cmd("a4,\r", "a4,65535,0\r", 0);
    cmd("a4,,\r", "a4,0,0\r", 0);
    cmd("d1,0,99\r", "d1,0,0\r", 0);
    cmd("m0,3\r", "m0,3,0\r", 0);
    cmd("m0,1\r", ",4\r", 1);
    cmd("000000000000000000000000000000000\r", ",5\r", 1);
    bus(1'b1, 4'h1, 32'hFFFFFFFF);
    bus(1'b0, 4'h1, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b1, 4'h0, 32'h35);
    bus(1'b0, 4'h0, 32'h0);
    check("bus write", rd, 32'h35);
    cmd("b0\r", "b0,0,0\r", 0);
    check("starts", starts, 32'h1);
    cmd("m0,2\r", "m0,2,0\r", 0);
    check("latched", 32'(op_params), 32'h1D);
    bus(1'b0, 4'hC, 32'h0);
    check("operation", rd, 32'h35);
    cmd("b\r", ",6\r", 1);
    bus(1'b0, 4'h8, 32'h0);
    check("status", rd, 32'h00066202);
    @(posedge clock);
    op_done <= 1'b1;
    @(posedge clock);
    op_done <= 1'b0;
    cmd("b\r", "b0,0,0\r", 0);
    check("starts", starts, 32'h2);
    check("next op", 32'(op_params), 32'h15);
    check("framing", host.frame_bad, 32'h0);
    tally_and_finish();
  end
endmodule : ascii_serial_command_parser_tb

bind command_parser parser_checker #(.BIT_CYCLES(BIT_CYCLES)) chk (
  .clock(clock), .rstn(rstn), .rx_pin(rx_pin), .tx_pin(tx_pin),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .op_done(op_done), .op_start(op_start), .op_params(op_params));

// *** testbench/host_terminal.sv ***
// Host terminal model at the far end of the serial link
`timescale 1ns/10ps
module host_terminal #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic clock,
  output logic      to_dev,
  input  wire logic from_dev
);
  logic [7:0] rxq[$];
  int         frame_bad = 0;

  // Only data lines, no handshake; line idles at mark
  initial to_dev = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      to_dev <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge clock);
    end
  endtask : send_byte

  // Whole command including its single return
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_byte(s[i]);
    end
  endtask : send_str

  initial begin : rx_side
    logic [7:0] b;
    forever begin
      @(negedge from_dev);
      repeat (BIT_CYCLES / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge clock);
        b[i] = from_dev;
      end
      repeat (BIT_CYCLES) @(posedge clock);
      if (from_dev !== 1'b1) frame_bad++;
      rxq.push_back(b);
    end
  end
endmodule : host_terminal

// *** testbench/parser_checker.sv ***
// Port-level assertions for the command parser
`timescale 1ns/10ps
module parser_checker
  import parser_pkg::*;
#(
  parameter int BIT_CYCLES = 16
) (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        rx_pin,
  input wire logic        tx_pin,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        op_done,
  input wire logic        op_start,
  input wire settings_t   op_params
);
  logic [31:0] low_run;
  logic        req;

  assign req = avs_read | avs_write;

  // Length of the current low stretch on the transmit line
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      low_run <= '0;
    end else if (tx_pin) begin
      low_run <= '0;
    end else begin
      low_run <= low_run + 1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_wait_single: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held beyond one wait state");
  a_idle_no_wait: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high without a request");
  a_new_req_wait: assert property ($rose(req) |-> avs_waitrequest)
    else $error("new request answered without a wait state");
  a_tx_bit_len: assert property (
    $rose(tx_pin) |-> low_run != 0 && low_run % BIT_CYCLES == 0
      && low_run <= 9 * BIT_CYCLES)
    else $error("low stretch on tx is not whole bit times");
  a_start_single: assert property (op_start |=> !op_start)
    else $error("op_start longer than one cycle");
  a_params_latch: assert property (
    $changed(op_params) |-> op_start)
    else $error("op_params changed away from a begin");
  a_rd_hold: assert property (
    $changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("readdata changed without a read");
  a_unmapped_zero: assert property (
    avs_read && avs_waitrequest && avs_address[1:0] != 2'h0
      |=> avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero");
endmodule : parser_checker
